// ### design/spd_bank.sv
// synth-3 post-divider bank: registers, engines and output select
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps

// Summary of operation
// RULE1: top nibble all ones gives frame pulse
// RULE2: otherwise 50% clock, whole setting is ratio
// RULE3: software keeps ratio at or below maximum
// RULE4: output frequency is source clock over ratio; the code runs a ratio of 1 as 2
// RULE5: low sixteen bits space pulses in periods
// RULE6: select field picks related clock; one-period pulse
// RULE7: a: 01 b, 10 c, 11 d
// RULE8: b: 00 a, 10 c, 11 d
// RULE9: c: 00 a, 01 b, 11 d
// RULE10: software never selects divider's own output
// RULE11: bit 18 inverts the pulse
// RULE12: bit 19 picks mid or edge boundary
// RULE13: related clock only from this synthesizer
// RULE14: multi-byte setting takes effect as one
module spd_bank #(
    parameter int SET_W = spd_pkg::SET_W
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // divider d output, from elsewhere in synth 3
    input wire logic div_d_clk_i,
    // divider outputs a, b, c
    output logic [2:0] div_clk_o
);
    if (SET_W != spd_pkg::SET_W) begin : g_chk
        $error("setting width is fixed by the field layout");
    end

    // ********************
    // state
    // ********************
    typedef struct packed {
        logic [2:0][SET_W-1:0] act; // committed settings
        logic [2:0][15:0] stg; // staged upper two bytes
        logic [7:0] rdata; // read answer
        logic [2:0] out; // channel outputs
    } spd_bank_t;

    spd_bank_t st_reg, st_next;

    logic [2:0] div_w; // divider engine outputs
    logic [2:0] frm_w; // frame engine outputs
    logic [3:0] sib_w; // all four synth-3 outputs
    logic [2:0] frm_mode; // channel in frame mode

    // ********************
    // address helpers
    // ********************
    // base offset of a channel
    function automatic logic [7:0] base_of(input int unsigned ch);
        case (ch)
            0: begin
                return spd_pkg::OFS_A;
            end
            1: begin
                return spd_pkg::OFS_B;
            end
            default: begin
                return spd_pkg::OFS_C;
            end
        endcase
    endfunction

    // byte k of a channel, k=0 is the top byte
    function automatic logic [7:0] byte_addr(input int unsigned ch, input int unsigned k);
        return 8'(base_of(ch) + 8'(k));
    endfunction

    // byte k of a setting
    function automatic logic [7:0] byte_of(input logic [SET_W-1:0] s, input int unsigned k);
        case (k)
            0: begin
                return s[23:16];
            end
            1: begin
                return s[15:8];
            end
            default: begin
                return s[7:0];
            end
        endcase
    endfunction

    // ********************
    // next state
    // ********************
    always_comb begin
        st_next = st_reg;
        // read data stand for one cycle only
        st_next.rdata = 8'h00;
        for (int unsigned i = 0; i < 3; i++) begin
            frm_mode[i] = spd_pkg::is_frame(st_reg.act[i]);
            // upper bytes only stage; the engines never see them alone
            if (wr_i && addr_i == byte_addr(i, 0)) begin
                st_next.stg[i][15:8] = wdata_i; // [RULE14]
            end
            if (wr_i && addr_i == byte_addr(i, 1)) begin
                st_next.stg[i][7:0] = wdata_i; // [RULE14]
            end
            // low byte commits all three bytes at once
            if (wr_i && addr_i == byte_addr(i, 2)) begin
                st_next.act[i] = {st_reg.stg[i], wdata_i}; // [RULE14]
            end
            for (int unsigned k = 0; k < 3; k++) begin
                if (rd_i && addr_i == byte_addr(i, k)) begin
                    st_next.rdata = byte_of(st_reg.act[i], k);
                end
            end
            // output select per channel
            st_next.out[i] = frm_mode[i] ? frm_w[i] : div_w[i]; // [RULE1] [RULE2]
        end
        // live status; unmapped reads answer zero
        if (rd_i && addr_i == spd_pkg::OFS_STAT) begin
            st_next.rdata = 8'h00;
            st_next.rdata[spd_pkg::STAT_OUT_LO +: 3] = st_reg.out;
            st_next.rdata[spd_pkg::STAT_FRM_LO +: 3] = frm_mode;
        end
    end

    // ********************
    // state register
    // ********************
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_reg <= '0;
            st_reg.act <= {3{spd_pkg::RESET_SET}};
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata_o = st_reg.rdata;
    assign div_clk_o = st_reg.out;

    // related clocks come only from this bank and divider d
    assign sib_w = {div_d_clk_i, st_reg.out}; // [RULE13]

    // ********************
    // channel engines
    // ********************
    for (genvar g = 0; g < 3; g++) begin : g_ch
        spd_chan_if u_if ();

        // engines see the committed setting only
        assign u_if.setting = st_reg.act[g];
        assign u_if.sib = sib_w;
        assign div_w[g] = u_if.div_out;
        assign frm_w[g] = u_if.frm_out;

        // ratio divider
        spd_clkdiv #(
            .CNT_W(SET_W)
        ) u_div (
            .clk_sys_i(clk_sys_i),
            .rst_i(rst_i),
            .ch(u_if.div)
        );

        // frame pulse shaper
        spd_frame #(
            .IDX(2'(g))
        ) u_frm (
            .clk_sys_i(clk_sys_i),
            .rst_i(rst_i),
            .ch(u_if.frm)
        );
    end

    // ********************
    // checks
    // ********************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    for (genvar g = 0; g < 3; g++) begin : g_chk_ch
        property p_frm_sel;
            frm_mode[g] |=> st_reg.out[g] == $past(frm_w[g]);
        endproperty
        a_frm_sel: assert property (p_frm_sel) else $error("frame mode output not from shaper"); // [RULE1]

        property p_div_sel;
            !frm_mode[g] |=> st_reg.out[g] == $past(div_w[g]);
        endproperty
        a_div_sel: assert property (p_div_sel) else $error("clock mode output not from divider"); // [RULE2]

        sequence s_upper_write;
            wr_i && (addr_i == byte_addr(g, 0) || addr_i == byte_addr(g, 1));
        endsequence

        property p_hold;
            s_upper_write |=> $stable(st_reg.act[g]);
        endproperty
        a_hold: assert property (p_hold) else $error("partial write changed setting"); // [RULE14]

        property p_commit;
            wr_i && addr_i == byte_addr(g, 2) |=> st_reg.act[g] == {$past(st_reg.stg[g]), $past(wdata_i)};
        endproperty
        a_commit: assert property (p_commit) else $error("setting not committed whole"); // [RULE14]
    end

    property p_rd_window;
        !$past(rd_i) |-> st_reg.rdata == 8'h00;
    endproperty
    a_rd_window: assert property (p_rd_window) else $error("read data outside answer cycle");
endmodule

// ### design/spd_clkdiv.sv
// divider engine for one channel, 50% duty at even ratios
`timescale 1ns/10ps
module spd_clkdiv #(
    parameter int CNT_W = spd_pkg::SET_W
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // channel
    spd_chan_if.div ch
);
    if (CNT_W != spd_pkg::SET_W) begin : g_chk
        $error("divider counter must match setting width");
    end

    typedef struct packed {
        logic [CNT_W-1:0] cnt; // position in period
        logic out; // divided clock
    } spd_div_t;

    spd_div_t st_reg, st_next;
    logic run; // divider active
    logic [CNT_W-1:0] n; // effective ratio
    logic [CNT_W-1:0] half; // high phase length
    logic rise_w; // output goes high next edge

    // ********************
    // divider
    // ********************
    // ratio 1 cannot be made from one edge, so it runs as 2
    always_comb begin
        run = !spd_pkg::is_frame(ch.setting) && ch.setting != '0; // [RULE1] [RULE3]
        n = (ch.setting < spd_pkg::MIN_RATIO) ? spd_pkg::MIN_RATIO : ch.setting;
        half = CNT_W'(({1'b0, n} + 25'h1) >> 1); // odd ratios get the extra cycle high
        st_next = st_reg;
        // >= so a shrunk ratio restarts at once
        st_next.cnt = (st_reg.cnt >= n - 1'b1) ? '0 : CNT_W'(st_reg.cnt + 1'b1); // [RULE4]
        if (!run) begin
            st_next.cnt = '0;
        end
        st_next.out = run && (st_next.cnt < half); // [RULE2]
        rise_w = st_next.out && !st_reg.out;
    end

    // state register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ch.div_out = st_reg.out;

    // ********************
    // checks
    // ********************
    logic [CNT_W:0] per_q; // cycles since last rise
    logic seen_q; // a rise seen under this setting
    logic [CNT_W-1:0] set_q; // setting one cycle ago
    always_ff @(posedge clk_sys_i) begin
        set_q <= ch.setting;
        if (rst_i || ch.setting != set_q || !run) begin
            seen_q <= 1'b0;
            per_q <= '0;
        end else if (rise_w) begin
            seen_q <= 1'b1;
            per_q <= 25'h1;
        end else begin
            per_q <= (CNT_W+1)'(per_q + 1'b1);
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    property p_period;
        rise_w && seen_q && ch.setting == set_q |-> per_q == {1'b0, n};
    endproperty
    a_period: assert property (p_period) else $error("divided period differs from ratio"); // [RULE4]

    property p_stop;
        !run |=> !st_reg.out && st_reg.cnt == '0;
    endproperty
    a_stop: assert property (p_stop) else $error("divider runs in frame mode"); // [RULE1]
endmodule

// ### design/spd_frame.sv
// frame pulse engine for one channel
`timescale 1ns/10ps
module spd_frame #(
    parameter logic [1:0] IDX = 2'h0 // own position, a=0 .. c=2
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // channel
    spd_chan_if.frm ch
);
    if (IDX > 2'h2) begin : g_chk
        $error("frame engine index out of range");
    end

    typedef struct packed {
        logic [15:0] cnt; // related periods since boundary
        logic rel_q; // related clock last cycle
        logic p; // pulse, true polarity
    } spd_frm_t;

    spd_frm_t st_reg, st_next;
    logic frm; // frame mode
    logic [1:0] sel; // related clock code
    logic rel_w; // related clock
    logic rise_w, fall_w; // related clock edges
    logic [15:0] last; // final count of frame

    // ********************
    // pulse shaping
    // ********************
    always_comb begin
        frm = spd_pkg::is_frame(ch.setting); // [RULE1]
        sel = ch.setting[spd_pkg::SEL_HI:spd_pkg::SEL_LO];
        // own code is reserved: no related clock, no pulses
        rel_w = (sel == IDX) ? 1'b0 : ch.sib[sel]; // [RULE7] [RULE8] [RULE9] [RULE10]
        rise_w = rel_w && !st_reg.rel_q;
        fall_w = !rel_w && st_reg.rel_q;
        // a zero period behaves as one
        last = ch.setting[spd_pkg::PER_HI:spd_pkg::PER_LO];
        last = (last == 16'h0000) ? 16'h0000 : 16'(last - 1'b1);
        st_next = st_reg;
        st_next.rel_q = rel_w;
        if (!frm) begin
            st_next.cnt = '0;
            st_next.p = 1'b0;
        end else begin
            if (rise_w) begin
                st_next.cnt = (st_reg.cnt >= last) ? '0 : 16'(st_reg.cnt + 1'b1); // [RULE5]
                // edge style: high for the related period after the boundary
                if (ch.setting[spd_pkg::TYPE_BIT]) begin
                    st_next.p = (st_next.cnt == '0); // [RULE6] [RULE12]
                end
            end
            // mid style: high from the falling edge before the boundary
            if (fall_w && !ch.setting[spd_pkg::TYPE_BIT]) begin
                st_next.p = (st_reg.cnt == last); // [RULE6] [RULE12]
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ch.frm_out = st_reg.p ^ ch.setting[spd_pkg::POL_BIT]; // [RULE11]

    // ********************
    // checks
    // ********************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s_last_rise;
        frm && rise_w && st_reg.cnt >= last;
    endsequence

    property p_wrap;
        s_last_rise |=> st_reg.cnt == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("frame count did not wrap"); // [RULE5]

    property p_edge_pulse;
        s_last_rise ##0 ch.setting[spd_pkg::TYPE_BIT] |=> st_reg.p;
    endproperty
    a_edge_pulse: assert property (p_edge_pulse) else $error("edge pulse missing at boundary"); // [RULE12]

    property p_change_on_edge;
        frm && $changed(st_reg.p) && $past(frm) |-> $past(rise_w || fall_w);
    endproperty
    a_change_on_edge: assert property (p_change_on_edge) else $error("pulse moved off related edge"); // [RULE6]

    property p_mid_start;
        frm && !ch.setting[spd_pkg::TYPE_BIT] && $stable(ch.setting) && $rose(st_reg.p) |-> $past(fall_w);
    endproperty
    a_mid_start: assert property (p_mid_start) else $error("mid pulse began off falling edge"); // [RULE12]

    property p_reserved;
        sel == IDX |-> !rel_w;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code picked a clock"); // [RULE10]

    property p_pol;
        frm && !st_reg.p && ch.setting[spd_pkg::POL_BIT] |-> ch.frm_out;
    endproperty
    a_pol: assert property (p_pol) else $error("inverted pulse idle level wrong"); // [RULE11]
endmodule

// ### shared/spd_chan_if.sv
// one channel's setting and clocks between the bank and its engines
`timescale 1ns/10ps
interface spd_chan_if;
    logic [spd_pkg::SET_W-1:0] setting; // committed setting
    logic [3:0] sib; // outputs a, b, c and d
    logic div_out; // divided clock
    logic frm_out; // shaped frame pulse
    modport ctl (output setting, output sib, input div_out, input frm_out);
    modport div (input setting, output div_out);
    modport frm (input setting, input sib, output frm_out);
endinterface

// ### shared/spd_pkg.sv
// constants shared by the synth-3 post-divider bank
package spd_pkg;

    // ********************
    // register map
    // ********************
    localparam int SET_W = 24; // one divider setting
    localparam logic [7:0] OFS_A = 8'ha4; // ratio_divider_a
    localparam logic [7:0] OFS_B = 8'ha7; // ratio_divider_b
    localparam logic [7:0] OFS_C = 8'haa; // ratio_divider_c
    localparam logic [7:0] OFS_STAT = 8'hc0; // live state
    localparam logic [SET_W-1:0] RESET_SET = 24'h000000;

    // ********************
    // setting fields
    // ********************
    localparam int MODE_HI = 23;
    localparam int MODE_LO = 20;
    localparam logic [3:0] MODE_FRAME = 4'hf;
    localparam int TYPE_BIT = 19; // 1: edge-aligned boundary
    localparam int POL_BIT = 18; // 1: inverted pulse
    localparam int SEL_HI = 17;
    localparam int SEL_LO = 16;
    localparam int PER_HI = 15;
    localparam int PER_LO = 0;
    localparam logic [SET_W-1:0] MAX_RATIO = 24'hefffff;
    localparam logic [SET_W-1:0] MIN_RATIO = 24'h000002;

    // ********************
    // status fields
    // ********************
    localparam int STAT_OUT_LO = 0; // three output levels
    localparam int STAT_FRM_LO = 3; // three frame-mode flags

    // frame mode test
    function automatic logic is_frame(input logic [SET_W-1:0] s);
        return s[MODE_HI:MODE_LO] == MODE_FRAME;
    endfunction

endpackage

// ### testbench/tb_spd_bank.sv
// self-checking bench for the synth-3 post-divider bank
`timescale 1ns/10ps
module tb_spd_bank;
    // ********************
    // stimulus and observed signals
    // ********************
    logic clk_sys_i = 1'b0; // stands for the vco clock
    logic rst_i = 1'b1; // held over the first edges
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic div_d_clk_i = 1'b0; // divider d, made here
    logic [2:0] div_clk_o;
    int errors = 0; // mismatches seen
    int num_checks = 0; // comparisons made
    logic [31:0] seed = 32'hbc09578b; // fixed, so runs repeat
    int d_cnt = 0; // divider d phase

    // ********************
    // clocks and design
    // ********************
    // 250 mhz system clock
    always #2 clk_sys_i = ~clk_sys_i;

    // divider d stand-in: period of six cycles, synchronous to the system clock
    always @(posedge clk_sys_i) begin
        if (d_cnt == 2) begin
            d_cnt <= 0;
            div_d_clk_i <= ~div_d_clk_i;
        end else begin
            d_cnt <= d_cnt + 1;
        end
    end

    spd_bank #(.SET_W(spd_pkg::SET_W)) u_dut (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .div_d_clk_i(div_d_clk_i),
        .div_clk_o(div_clk_o)
    );

    // ********************
    // helpers
    // ********************
    // xorshift source, advances the shared seed
    function logic [31:0] rnd();
        logic [31:0] x;
        x = seed;
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        seed = x;
        return x;
    endfunction

    // base address of a channel's setting
    function logic [7:0] base(input int ch);
        return (ch == 0) ? spd_pkg::OFS_A : (ch == 1) ? spd_pkg::OFS_B : spd_pkg::OFS_C;
    endfunction

    // compare a register or output value
    task chk_val(input string what, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // compare a cycle count
    task chk_cnt(input string what, input int exp, input int got);
        num_checks++;
        if (got != exp) begin
            errors++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask

    // write bytes lo..hi of a setting; strobe held so no signal is set twice per step
    task wr_bytes(input int ch, input logic [23:0] v, input int lo, input int hi);
        int i;
        wr_i <= 1'b1;
        for (i = lo; i <= hi; i++) begin
            addr_i <= base(ch) + 8'(i);
            wdata_i <= v[23-8*i -: 8];
            @(posedge clk_sys_i);
        end
        wr_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    // one read; data taken mid answer cycle, where they are settled
    task rd_byte(input logic [7:0] a, output logic [7:0] d);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        @(negedge clk_sys_i);
        d = rdata_o;
        @(posedge clk_sys_i);
    endtask

    // read back a whole committed setting
    task rd_set(input int ch, output logic [23:0] v);
        logic [7:0] b;
        int i;
        for (i = 0; i < 3; i++) begin
            rd_byte(base(ch) + 8'(i), b);
            v[23-8*i -: 8] = b;
        end
    endtask

    // active width and edge-to-edge period of one output; bounded waits
    task measure(input int ch, input logic lvl, output int hi, output int per);
        int n;
        n = 0;
        hi = 0;
        per = 0;
        while (div_clk_o[ch] !== ~lvl && n < 2000) begin
            @(posedge clk_sys_i);
            n++;
        end
        while (div_clk_o[ch] !== lvl && n < 4000) begin
            @(posedge clk_sys_i);
            n++;
        end
        while (div_clk_o[ch] === lvl && per < 2000) begin
            @(posedge clk_sys_i);
            hi++;
            per++;
        end
        while (div_clk_o[ch] !== lvl && per < 4000) begin
            @(posedge clk_sys_i);
            per++;
        end
    endtask

    // the single place the run ends
    task print_verdict();
        $display("checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ********************
    // watchdog
    // ********************
    // the whole sequence needs under two thousand cycles; this is ample margin
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        errors++;
        print_verdict();
    end

    // ********************
    // main sequence
    // ********************
    initial begin
        logic [23:0] v;
        logic [23:0] w;
        logic [7:0] b;
        logic pol;
        logic typ;
        int ch;
        int sel;
        int k;
        int n;
        int r;
        int p;
        int hi;
        int per;
        int it;
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        // reset values, unmapped read
        for (ch = 0; ch < 3; ch++) begin
            rd_set(ch, v);
            chk_val("reset setting", spd_pkg::RESET_SET, v);
        end
        chk_val("outputs after reset", 24'h000000, {21'h000000, div_clk_o});
        rd_byte(8'h50, b);
        chk_val("unmapped read", 24'h000000, {16'h0000, b});
        // round trip, first at the largest legal ratio
        for (k = 0; k < 6; k++) begin
            w = 24'(rnd());
            v = (k == 0) ? spd_pkg::MAX_RATIO : {4'(rnd() % 15), w[19:0]};
            wr_bytes(k % 3, v, 0, 2);
            rd_set(k % 3, w);
            chk_val("setting readback", v, w);
        end
        // staged bytes alone must not move the committed value
        v = 24'h000006;
        wr_bytes(0, v, 0, 2);
        wr_bytes(0, 24'h12345a, 0, 1);
        rd_set(0, w);
        chk_val("partial write", v, w);
        wr_bytes(0, 24'h000008, 2, 2);
        rd_set(0, w);
        chk_val("low byte commit", 24'h123408, w);
        // clock mode: period and high time, smallest ratios first
        for (k = 0; k < 6; k++) begin
            n = (k < 2) ? 2 + k : 2 + int'(rnd() % 9);
            wr_bytes(k % 3, 24'(n), 0, 2);
            repeat (30) @(posedge clk_sys_i);
            measure(k % 3, 1'b1, hi, per);
            chk_cnt("clock period", n, per);
            chk_cnt("clock high time", (n + 1) / 2, hi);
        end
        // frame mode: every legal select of every channel, all style and polarity mixes
        it = 0;
        for (ch = 0; ch < 3; ch++) begin
            for (sel = 0; sel < 4; sel++) begin
                if (sel == ch) continue;
                r = (sel == 3) ? 6 : 4 + 2 * int'(rnd() % 3);
                p = 2 + int'(rnd() % 3);
                pol = it[0];
                typ = it[1];
                if (sel != 3) wr_bytes(sel, 24'(r), 0, 2);
                wr_bytes(ch, {spd_pkg::MODE_FRAME, typ, pol, 2'(sel), 16'(p)}, 0, 2);
                repeat (40) @(posedge clk_sys_i);
                measure(ch, ~pol, hi, per);
                chk_cnt("pulse width", r, hi);
                chk_cnt("frame spacing", p * r, per);
                it++;
            end
        end
        // only channel c is left in frame mode
        rd_byte(spd_pkg::OFS_STAT, b);
        chk_val("frame flags", 24'h000004, {21'h000000, b[5:3]});
        // reset in mid-run clears settings and outputs
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        rd_set(2, v);
        chk_val("setting after second reset", spd_pkg::RESET_SET, v);
        chk_val("outputs after second reset", 24'h000000, {21'h000000, div_clk_o});
        print_verdict();
    end
endmodule
